// *** hdl/csmc_pkg.sv ***
// Package: constants, field layouts and types of the setup mode controller
package csmc_pkg;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_HZ = 125_000_000;
  localparam int HOLD_MS = 2000;
  localparam int DEB_US = 10000;
  localparam int FLASH_MS = 250;
  localparam int HOLD_CYC = HOLD_MS * (CLK_HZ / 1000);
  localparam int DEB_CYC = DEB_US * (CLK_HZ / 1000000);
  localparam int FLASH_CYC = FLASH_MS * (CLK_HZ / 1000);
  // ----------------------------------------
  // Panel layout
  // ----------------------------------------
  localparam int NSRC = 7;
  localparam int NBTN = 19;
  localparam int B_SETUP = 0;
  localparam int B_SRC = 1;
  localparam int B_HP = 8;
  localparam int B_REC = 9;
  localparam int B_ATT = 10;
  localparam int B_STUDIO = 11;
  localparam int B_MONO = 12;
  localparam int B_COMM = 13;
  localparam int B_LVLUP = 16;
  localparam int B_REMOTE = 17;
  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [11:0] OFF_CTRL = 12'h000;
  localparam logic [11:0] OFF_STATUS = 12'h004;
  localparam logic [11:0] OFF_COMMIT = 12'h008;
  localparam logic [11:0] OFF_PEND = 12'h00c;
  localparam int CTRL_LOCK = 0;
  localparam int CTRL_NVSTORE = 1;
  localparam logic [1:0] CTRL_RST = 2'h2;
  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {
    ST_NORMAL = 2'b00,
    ST_ARM = 2'b01,
    ST_SETUP = 2'b11,
    ST_EXIT = 2'b10
  } csmc_state_t;
  typedef struct packed {
    logic [6:0] sens;
    logic [6:0] mono;
    logic rec_hi;
    logic [5:0] atten;
    logic studio_hp;
    logic mono_latch;
    logic auto_cancel;
    logic [2:0] comm_latch;
    logic hp_follow_cr;
  } csmc_cfg_t;
  localparam csmc_cfg_t CFG_DEFAULT = '{sens: 7'h00, mono: 7'h00, rec_hi: 1'b0, atten: 6'h04,
    studio_hp: 1'b0, mono_latch: 1'b0, auto_cancel: 1'b1, comm_latch: 3'h0, hp_follow_cr: 1'b0};
endpackage

// *** hdl/csmc_top.sv ***
// Top: console setup mode controller with APB register slave
`timescale 1ns/10ps
`default_nettype none
module csmc_top #(
  parameter int HOLD_CYC = csmc_pkg::HOLD_CYC,
  parameter int DEB_CYC = csmc_pkg::DEB_CYC,
  parameter int FLASH_CYC = csmc_pkg::FLASH_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [18:0] btn_pins,
  input wire logic pot_change,
  input wire logic nv_valid,
  input wire csmc_pkg::csmc_cfg_t nv_rdata,
  output logic nv_store,
  output csmc_pkg::csmc_cfg_t nv_wdata,
  output logic [6:0] red_led,
  output logic [6:0] green_led,
  output logic [6:0] orange_led,
  output logic setup_led,
  output logic studio_led,
  output logic mono_led,
  output logic atten_led,
  output logic [2:0] comm_led,
  output logic input7_hi_led,
  output logic rec_hi_led,
  output logic audio_mute,
  output logic cr_atten,
  output logic cr_mono,
  output logic [2:0] comm_active,
  output csmc_pkg::csmc_cfg_t active_cfg
);
  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic [18:0] sync1_q, sync2_q, samp_q, deb_q, deb_prev_q;
  logic [31:0] deb_cnt_q, hold_cnt_q, flash_cnt_q;
  logic flash_q, loaded_q, atten_q, mono_q;
  logic [2:0] comm_lat_q, comm_prev_q;
  logic [6:0] cr_src_q;
  logic [1:0] ctrl_q;
  csmc_pkg::csmc_state_t state_q;
  csmc_pkg::csmc_cfg_t cur_q, pend_q;
  logic [18:0] press;
  logic [6:0] src_press;
  logic hp_held, rec_held, alt_held, in_setup, hold_done, dflt_combo;
  logic [2:0] comm_now;

  function automatic logic [31:0] apb_read(input logic [11:0] a, input logic [1:0] c,
      input csmc_pkg::csmc_state_t s, input logic at, input logic mo, input logic [2:0] cm,
      input csmc_pkg::csmc_cfg_t cc, input csmc_pkg::csmc_cfg_t pc);
    case (a)
      csmc_pkg::OFF_CTRL: apb_read = {30'h0, c};
      csmc_pkg::OFF_STATUS: apb_read = {25'h0, cm, mo, at, s};
      csmc_pkg::OFF_COMMIT: apb_read = {4'h0, cc};
      csmc_pkg::OFF_PEND: apb_read = {4'h0, pc};
      default: apb_read = 32'h0;
    endcase
  endfunction

  function automatic logic addr_ok(input logic [11:0] a);
    addr_ok = (a == csmc_pkg::OFF_CTRL) || (a == csmc_pkg::OFF_STATUS) ||
      (a == csmc_pkg::OFF_COMMIT) || (a == csmc_pkg::OFF_PEND);
  endfunction

  // ----------------------------------------
  // Synchronise and debounce
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_q <= 19'h0;
      sync2_q <= 19'h0;
    end else begin
      sync1_q <= btn_pins;
      sync2_q <= sync1_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      deb_cnt_q <= 32'h0;
      samp_q <= 19'h0;
      deb_q <= 19'h0;
      deb_prev_q <= 19'h0;
    end else begin
      deb_prev_q <= deb_q;
      if (deb_cnt_q >= 32'(DEB_CYC - 1)) begin
        deb_cnt_q <= 32'h0;
        samp_q <= sync2_q;
        deb_q <= (samp_q == sync2_q) ? sync2_q : deb_q;
      end else begin
        deb_cnt_q <= deb_cnt_q + 32'h1;
      end
    end
  end

  assign press = deb_q & ~deb_prev_q;
  assign src_press = press[csmc_pkg::B_SRC +: csmc_pkg::NSRC];
  assign hp_held = deb_q[csmc_pkg::B_HP];
  assign rec_held = deb_q[csmc_pkg::B_REC];
  assign alt_held = deb_q[csmc_pkg::B_LVLUP];
  assign in_setup = (state_q == csmc_pkg::ST_SETUP);
  assign dflt_combo = in_setup && hp_held && rec_held;
  assign hold_done = (hold_cnt_q >= 32'(HOLD_CYC - 1));

  // ----------------------------------------
  // Mode state machine
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_cnt_q <= 32'h0;
    end else if ((state_q == csmc_pkg::ST_ARM && deb_q[csmc_pkg::B_SETUP]) || dflt_combo) begin
      hold_cnt_q <= hold_done ? 32'h0 : hold_cnt_q + 32'h1;
    end else begin
      hold_cnt_q <= 32'h0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= csmc_pkg::ST_NORMAL;
    end else begin
      case (state_q)
        csmc_pkg::ST_NORMAL: begin
          if (press[csmc_pkg::B_SETUP] && !ctrl_q[csmc_pkg::CTRL_LOCK]) begin
            state_q <= csmc_pkg::ST_ARM;
          end
        end
        csmc_pkg::ST_ARM: begin
          if (!deb_q[csmc_pkg::B_SETUP]) begin
            state_q <= csmc_pkg::ST_NORMAL;
          end else if (hold_done) begin
            state_q <= csmc_pkg::ST_SETUP;
          end
        end
        csmc_pkg::ST_SETUP: begin
          if (press[csmc_pkg::B_SETUP] || (dflt_combo && hold_done)) begin
            state_q <= csmc_pkg::ST_EXIT;
          end
        end
        csmc_pkg::ST_EXIT: state_q <= csmc_pkg::ST_NORMAL;
        default: state_q <= csmc_pkg::ST_NORMAL;
      endcase
    end
  end

  // ----------------------------------------
  // Pending and committed settings
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_q <= csmc_pkg::CFG_DEFAULT;
    end else if (state_q == csmc_pkg::ST_NORMAL && nv_valid && !loaded_q) begin
      pend_q <= nv_rdata;
    end else if (dflt_combo && hold_done) begin
      pend_q <= csmc_pkg::CFG_DEFAULT;
    end else if (in_setup && alt_held) begin
      if (hp_held && src_press[0]) begin
        pend_q.hp_follow_cr <= ~pend_q.hp_follow_cr;
      end
    end else if (in_setup) begin
      if (hp_held) begin
        pend_q.mono <= pend_q.mono ^ src_press;
      end else if (rec_held) begin
        if (src_press[0]) begin
          pend_q.rec_hi <= ~pend_q.rec_hi;
        end else if (src_press[6:1] != 6'h0) begin
          pend_q.atten <= src_press[6:1] & ~(src_press[6:1] - 6'h1);
        end
      end else begin
        pend_q.sens <= pend_q.sens ^ src_press;
      end
      if (press[csmc_pkg::B_STUDIO]) begin
        pend_q.studio_hp <= ~pend_q.studio_hp;
      end
      if (press[csmc_pkg::B_MONO]) begin
        pend_q.mono_latch <= ~pend_q.mono_latch;
      end
      if (press[csmc_pkg::B_ATT]) begin
        pend_q.auto_cancel <= ~pend_q.auto_cancel;
      end
      pend_q.comm_latch <= pend_q.comm_latch ^ press[csmc_pkg::B_COMM +: 3];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur_q <= csmc_pkg::CFG_DEFAULT;
      loaded_q <= 1'b0;
      nv_store <= 1'b0;
      nv_wdata <= csmc_pkg::CFG_DEFAULT;
    end else begin
      nv_store <= 1'b0;
      if (state_q == csmc_pkg::ST_NORMAL && nv_valid && !loaded_q) begin
        cur_q <= nv_rdata;
        loaded_q <= 1'b1;
      end else if (state_q == csmc_pkg::ST_EXIT) begin
        cur_q <= pend_q;
        nv_store <= ctrl_q[csmc_pkg::CTRL_NVSTORE];
        nv_wdata <= pend_q;
      end
    end
  end

  // ----------------------------------------
  // Normal operation functions
  // ----------------------------------------
  assign comm_now = (cur_q.comm_latch & comm_lat_q) |
    (~cur_q.comm_latch & deb_q[csmc_pkg::B_COMM +: 3]) |
    {1'b0, deb_q[csmc_pkg::B_REMOTE +: 2]};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      comm_lat_q <= 3'h0;
      comm_prev_q <= 3'h0;
      atten_q <= 1'b0;
      mono_q <= 1'b0;
      cr_src_q <= 7'h01;
    end else if (state_q != csmc_pkg::ST_NORMAL) begin
      comm_lat_q <= 3'h0;
      comm_prev_q <= 3'h0;
      atten_q <= 1'b0;
      mono_q <= 1'b0;
    end else begin
      comm_prev_q <= comm_now;
      comm_lat_q <= comm_lat_q ^ press[csmc_pkg::B_COMM +: 3];
      if ((comm_now & ~comm_prev_q) != 3'h0) begin
        atten_q <= 1'b1;
      end else if (press[csmc_pkg::B_ATT]) begin
        atten_q <= ~atten_q;
      end else if (pot_change && cur_q.auto_cancel) begin
        atten_q <= 1'b0;
      end
      if (cur_q.mono_latch) begin
        mono_q <= mono_q ^ press[csmc_pkg::B_MONO];
      end else begin
        mono_q <= deb_q[csmc_pkg::B_MONO];
      end
      if (src_press != 7'h0 && !hp_held) begin
        cr_src_q <= src_press & ~(src_press - 7'h1);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flash_cnt_q <= 32'h0;
      flash_q <= 1'b0;
    end else if (flash_cnt_q >= 32'(FLASH_CYC - 1)) begin
      flash_cnt_q <= 32'h0;
      flash_q <= ~flash_q;
    end else begin
      flash_cnt_q <= flash_cnt_q + 32'h1;
    end
  end

  // ----------------------------------------
  // Outputs and LEDs
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      red_led <= 7'h0;
      green_led <= 7'h0;
      orange_led <= 7'h0;
      setup_led <= 1'b0;
      studio_led <= 1'b0;
      mono_led <= 1'b0;
      atten_led <= 1'b0;
      comm_led <= 3'h0;
      input7_hi_led <= 1'b0;
      rec_hi_led <= 1'b0;
      audio_mute <= 1'b0;
      cr_atten <= 1'b0;
      cr_mono <= 1'b0;
      comm_active <= 3'h0;
      active_cfg <= csmc_pkg::CFG_DEFAULT;
    end else begin
      input7_hi_led <= cur_q.sens[6];
      rec_hi_led <= cur_q.rec_hi;
      active_cfg <= cur_q;
      audio_mute <= in_setup;
      setup_led <= in_setup & flash_q;
      cr_atten <= atten_q;
      cr_mono <= mono_q;
      comm_active <= comm_now;
      if (in_setup && alt_held) begin
        red_led <= 7'h0;
        green_led <= {6'h0, pend_q.hp_follow_cr};
        orange_led <= 7'h0;
        studio_led <= 1'b0;
        mono_led <= 1'b0;
        atten_led <= 1'b0;
        comm_led <= 3'h0;
      end else if (in_setup) begin
        red_led <= pend_q.sens;
        green_led <= pend_q.mono;
        orange_led <= {pend_q.atten, pend_q.rec_hi};
        studio_led <= pend_q.studio_hp;
        mono_led <= pend_q.mono_latch;
        atten_led <= pend_q.auto_cancel;
        comm_led <= pend_q.comm_latch;
      end else begin
        red_led <= cr_src_q & ~(cur_q.mono & {7{flash_q}});
        green_led <= 7'h0;
        orange_led <= 7'h0;
        studio_led <= 1'b0;
        mono_led <= mono_q;
        atten_led <= atten_q;
        comm_led <= comm_now;
      end
    end
  end

  // ----------------------------------------
  // APB slave
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
      ctrl_q <= csmc_pkg::CTRL_RST;
    end else begin
      pready <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !addr_ok(paddr);
      prdata <= (psel && penable && !pready && !pwrite) ?
        apb_read(paddr, ctrl_q, state_q, atten_q, mono_q, comm_now, cur_q, pend_q) : 32'h0;
      if (psel && penable && pready && pwrite && paddr == csmc_pkg::OFF_CTRL) begin
        ctrl_q <= pwdata[1:0];
      end
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  property p_entry;
    @(posedge pclk) disable iff (!presetn)
      (state_q == csmc_pkg::ST_ARM ##1 state_q == csmc_pkg::ST_SETUP) |-> $past(hold_done);
  endproperty
  a_entry: assert property (p_entry) else $error("setup entered before hold time");

  property p_mute;
    @(posedge pclk) disable iff (!presetn)
      in_setup |=> audio_mute;
  endproperty
  a_mute: assert property (p_mute) else $error("audio not muted in setup");

  property p_commit;
    @(posedge pclk) disable iff (!presetn)
      in_setup |=> $stable(cur_q);
  endproperty
  a_commit: assert property (p_commit) else $error("committed settings changed in setup");

  property p_in7;
    @(posedge pclk) disable iff (!presetn)
      ##1 (input7_hi_led == $past(cur_q.sens[6]) && rec_hi_led == $past(cur_q.rec_hi));
  endproperty
  a_in7: assert property (p_in7) else $error("high-level LED not from committed value");

  property p_onehot;
    @(posedge pclk) disable iff (!presetn)
      $onehot(pend_q.atten) && $onehot(cur_q.atten);
  endproperty
  a_onehot: assert property (p_onehot) else $error("attenuation not one-hot");

  property p_remote;
    @(posedge pclk) disable iff (!presetn)
      (state_q == csmc_pkg::ST_NORMAL && deb_q[csmc_pkg::B_REMOTE]) |=> comm_active[0];
  endproperty
  a_remote: assert property (p_remote) else $error("remote contact not active");

  property p_mono_latch;
    @(posedge pclk) disable iff (!presetn)
      (state_q == csmc_pkg::ST_NORMAL && cur_q.mono_latch && press[csmc_pkg::B_MONO])
        |=> ##1 (cr_mono != $past(cr_mono));
  endproperty
  a_mono_latch: assert property (p_mono_latch) else $error("latching mono did not toggle");

  property p_sens_edge;
    @(posedge pclk) disable iff (!presetn)
      (in_setup && $past(in_setup) && $changed(pend_q.sens)) |-> ($past(src_press) != 7'h0);
  endproperty
  a_sens_edge: assert property (p_sens_edge) else $error("sensitivity changed without press");

  c_setup: cover property (@(posedge pclk) disable iff (!presetn) state_q == csmc_pkg::ST_SETUP);
  c_dflt: cover property (@(posedge pclk) disable iff (!presetn) dflt_combo && hold_done);
  c_alt: cover property (@(posedge pclk) disable iff (!presetn) in_setup && alt_held && src_press[0]);
endmodule // csmc_top
`default_nettype wire

// *** testbench/csmc_panel_model.sv ***
// Operator panel and nonvolatile store model for the setup mode controller
`timescale 1ns/10ps
`default_nettype none
module csmc_panel_model (
  input wire logic pclk,
  output logic [18:0] btn_pins,
  output logic pot_change,
  output logic nv_valid,
  output csmc_pkg::csmc_cfg_t nv_rdata,
  input wire logic nv_store,
  input wire csmc_pkg::csmc_cfg_t nv_wdata
);
  // ----------------------------------------
  // Store and buttons
  // ----------------------------------------
  csmc_pkg::csmc_cfg_t image_q;
  initial begin
    btn_pins = '0;
    pot_change = 1'b0;
    nv_valid = 1'b0;
    image_q = csmc_pkg::CFG_DEFAULT;
  end
  // Image not yet valid reads as garbage
  assign nv_rdata = nv_valid ? image_q : ~image_q;
  always @(posedge pclk) begin
    if (nv_store === 1'b1) begin
      image_q <= nv_wdata;
    end
  end
  task automatic preload(input csmc_pkg::csmc_cfg_t img);
    image_q = img;
    nv_valid = 1'b1;
  endtask
  // Buttons held as a level, changed just after an edge
  task automatic hold(input logic [18:0] m, input int cyc);
    @(posedge pclk);
    btn_pins <= m;
    repeat (cyc) @(posedge pclk);
  endtask
  task automatic nudge_pot();
    @(posedge pclk);
    pot_change <= 1'b1;
    @(posedge pclk);
    pot_change <= 1'b0;
  endtask
endmodule // csmc_panel_model
`default_nettype wire

// *** testbench/tb.sv ***
// Self-checking testbench for the console setup mode controller
`timescale 1ns/10ps
`default_nettype none
module tb;
  localparam int HC = 50;
  localparam int P = 24;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, er, nv_valid, nv_store, pot_change;
  logic [18:0] btn_pins;
  logic [6:0] red_led, green_led, orange_led;
  logic setup_led, studio_led, mono_led, atten_led, input7_hi_led, rec_hi_led, audio_mute, cr_atten, cr_mono;
  logic [2:0] comm_led, comm_active;
  logic [1:0] hi, lo;
  csmc_pkg::csmc_cfg_t nv_rdata, nv_wdata, active_cfg, pend, comm;
  int err_count = 0;
  int compares = 0;
  int cyc = 0;
  int n;

  always #4 pclk = ~pclk;

  csmc_top #(.HOLD_CYC(HC), .DEB_CYC(4), .FLASH_CYC(8)) csmc_top_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .btn_pins(btn_pins),
    .pot_change(pot_change), .nv_valid(nv_valid), .nv_rdata(nv_rdata), .nv_store(nv_store),
    .nv_wdata(nv_wdata), .red_led(red_led), .green_led(green_led), .orange_led(orange_led),
    .setup_led(setup_led), .studio_led(studio_led), .mono_led(mono_led), .atten_led(atten_led),
    .comm_led(comm_led), .input7_hi_led(input7_hi_led), .rec_hi_led(rec_hi_led), .audio_mute(audio_mute),
    .cr_atten(cr_atten), .cr_mono(cr_mono), .comm_active(comm_active), .active_cfg(active_cfg));

  csmc_panel_model csmc_panel_model_i (.pclk(pclk), .btn_pins(btn_pins), .pot_change(pot_change),
    .nv_valid(nv_valid), .nv_rdata(nv_rdata), .nv_store(nv_store), .nv_wdata(nv_wdata));

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic conclude();
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  function automatic logic [18:0] b(input int i);
    return 19'h1 << i;
  endfunction

  task automatic h(input logic [18:0] m, input int c);
    csmc_panel_model_i.hold(m, c);
  endtask

  task automatic press(input logic [18:0] mod, input logic [18:0] key);
    h(mod, P);
    h(mod | key, P);
    h(mod, P);
    h('0, P);
  endtask

  task automatic enter();
    h(b(csmc_pkg::B_SETUP), 2 * HC);
    h('0, P);
    pend = comm;
  endtask

  task automatic leds();
    chk("red", red_led, pend.sens);
    chk("green", green_led, pend.mono);
    chk("orange", orange_led, {pend.atten, pend.rec_hi});
    chk("onehot", $countones(orange_led[6:1]), 1);
    chk("studio", studio_led, pend.studio_hp);
    chk("monoled", mono_led, pend.mono_latch);
    chk("attled", atten_led, pend.auto_cancel);
    chk("commled", comm_led, pend.comm_latch);
    chk("commit", active_cfg, comm);
    chk("in7", input7_hi_led, comm.sens[6]);
    chk("rechi", rec_hi_led, comm.rec_hi);
  endtask

  task automatic watch();
    hi = '0;
    lo = '0;
    repeat (32) begin
      @(posedge pclk);
      hi = hi | {setup_led, red_led[0]};
      lo = lo | ~{setup_led, red_led[0]};
    end
  endtask

  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      conclude();
    end
  end

  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    void'($urandom(34946));
    comm = csmc_pkg::CFG_DEFAULT;
    comm.sens = 7'($urandom);
    repeat (10) @(posedge pclk);
    csmc_panel_model_i.preload(comm);
    presetn <= 1'b1;
    repeat (20) @(posedge pclk);
    chk("load", active_cfg, comm);
    apb(1'b0, csmc_pkg::OFF_CTRL, 32'h0);
    chk("ctrl", rd, 32'h2);
    chk("okerr", er, 1'b0);
    apb(1'b0, 12'h010, 32'h0);
    chk("unmapped", er, 1'b1);
    apb(1'b0, csmc_pkg::OFF_COMMIT, 32'h0);
    chk("commitreg", rd, comm);
    h(b(csmc_pkg::B_SETUP), HC / 2);
    h('0, HC + P);
    chk("short", audio_mute, 1'b0);
    h(b(csmc_pkg::B_MONO), P);
    chk("momheld", cr_mono, 1'b1);
    h('0, P);
    chk("momrel", cr_mono, 1'b0);
    apb(1'b1, csmc_pkg::OFF_CTRL, 32'h3);
    enter();
    chk("locked", audio_mute, 1'b0);
    apb(1'b1, csmc_pkg::OFF_CTRL, 32'h2);
    enter();
    chk("mute", audio_mute, 1'b1);
    apb(1'b0, csmc_pkg::OFF_STATUS, 32'h0);
    chk("state", rd[1:0], 2'h3);
    watch();
    chk("flash", {hi[1], lo[1]}, 2'h3);
    leds();
    n = $urandom % 6 + 1;
    press('0, b(csmc_pkg::B_SRC + n - 1));
    pend.sens[n - 1] ^= 1'b1;
    press('0, b(csmc_pkg::B_SRC + 6));
    pend.sens[6] ^= 1'b1;
    press(b(csmc_pkg::B_HP), b(csmc_pkg::B_SRC));
    pend.mono[0] ^= 1'b1;
    press(b(csmc_pkg::B_REC), b(csmc_pkg::B_SRC));
    pend.rec_hi ^= 1'b1;
    for (int k = 7; k >= 2; k--) begin
      press(b(csmc_pkg::B_REC), b(csmc_pkg::B_SRC + k - 1));
      pend.atten = 6'h1 << (k - 2);
      leds();
    end
    press('0, b(csmc_pkg::B_STUDIO));
    pend.studio_hp ^= 1'b1;
    press('0, b(csmc_pkg::B_MONO));
    pend.mono_latch ^= 1'b1;
    press('0, b(csmc_pkg::B_COMM));
    pend.comm_latch[0] ^= 1'b1;
    leds();
    press(b(csmc_pkg::B_LVLUP) | b(csmc_pkg::B_HP), b(csmc_pkg::B_SRC));
    h(b(csmc_pkg::B_LVLUP) | b(csmc_pkg::B_HP), P);
    h(b(csmc_pkg::B_LVLUP), P);
    pend.hp_follow_cr ^= 1'b1;
    chk("alt", green_led, {6'h00, pend.hp_follow_cr});
    chk("altred", red_led, 7'h00);
    h('0, P);
    press('0, b(csmc_pkg::B_SETUP));
    comm = pend;
    chk("unmute", audio_mute, 1'b0);
    chk("applied", active_cfg, comm);
    chk("in7x", input7_hi_led, comm.sens[6]);
    chk("rechix", rec_hi_led, comm.rec_hi);
    chk("stored", csmc_panel_model_i.image_q, comm);
    watch();
    chk("monoflash", {hi[0], lo[0]}, 2'h3);
    chk("idleled", hi[1], 1'b0);
    press('0, b(csmc_pkg::B_MONO));
    chk("latchon", cr_mono, 1'b1);
    press('0, b(csmc_pkg::B_MONO));
    chk("latchoff", cr_mono, 1'b0);
    press('0, b(csmc_pkg::B_ATT));
    chk("atton", cr_atten, 1'b1);
    csmc_panel_model_i.nudge_pot();
    repeat (4) @(posedge pclk);
    chk("autocancel", cr_atten, 1'b0);
    press('0, b(csmc_pkg::B_COMM));
    chk("talklatch", comm_active, 3'h1);
    chk("talkatt", cr_atten, 1'b1);
    press('0, b(csmc_pkg::B_COMM));
    chk("talkunlatch", comm_active, 3'h0);
    h(b(csmc_pkg::B_COMM + 1), P);
    chk("phonesheld", comm_active, 3'h2);
    h('0, P);
    chk("phonesrel", comm_active, 3'h0);
    h(b(csmc_pkg::B_REMOTE), P);
    chk("remoteheld", comm_active, 3'h1);
    h('0, P);
    chk("remoterel", comm_active, 3'h0);
    enter();
    h(b(csmc_pkg::B_HP) | b(csmc_pkg::B_REC), 2 * HC);
    h('0, P);
    comm = csmc_pkg::CFG_DEFAULT;
    chk("defexit", audio_mute, 1'b0);
    chk("defcfg", active_cfg, comm);
    chk("defstore", csmc_panel_model_i.image_q, comm);
    conclude();
  end
endmodule // tb
`default_nettype wire
